// file: hdl/dthm_drive_modes.sv
// profile torque and homing mode control with status word generation
// assumes all inputs are synchronous to sys_clk; travel profiles of the
// individual homing methods live outside and report through index_phase, ref_found and home_fault
module dthm_drive_modes
	import dthm_pkg::*;
#(
	parameter int unsigned TICK_CYC = MS_CYCLES
) (
	input wire logic sys_clk, // control clock
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] mode_sel, // modes of operation
	input wire logic [15:0] ctrl_word, // control word
	input wire logic submode_sel, // 1 pure torque, 0 limited velocity
	input wire logic signed [15:0] target_torque, // per-mille
	input wire logic [15:0] max_torque, // per-mille
	input wire logic [15:0] max_current, // per-mille
	input wire logic [15:0] motor_current_cap, // per-mille
	input wire logic [15:0] overload_time, // nonzero allows above rated
	input wire logic [31:0] torque_slope, // per-mille per second
	input wire logic signed [15:0] torque_offset, // per-mille
	input wire logic [15:0] torque_window, // per-mille
	input wire logic [15:0] torque_window_ms, // window time in ms
	input wire logic signed [15:0] torque_actual, // per-mille
	input wire logic speed_zero, // actual speed is zero
	input wire logic [15:0] motor_current, // current magnitude
	input wire logic signed [31:0] home_offset, // user units
	input wire logic signed [7:0] homing_method, // method number
	input wire logic [31:0] speed_switch, // switch search speed
	input wire logic [31:0] speed_index, // index search speed
	input wire logic [31:0] homing_accel, // homing acceleration
	input wire logic [15:0] block_current, // block threshold
	input wire logic [15:0] block_period_ms, // push time in ms
	input wire logic index_phase, // method logic seeks index
	input wire logic ref_found, // method logic found reference
	input wire logic home_fault, // method logic reports error
	output logic [15:0] status_word, // status word
	output logic signed [15:0] torque_demand, // ramp output
	output logic signed [15:0] torque_set, // set value to controller
	output logic motor_hold, // hold motor stopped
	output logic speed_limit_en, // honour max speed limit
	output logic field_weak_en, // field weakening allowed
	output logic homing_active, // homing travel in progress
	output logic signed [7:0] method_cmd, // method for travel logic
	output logic [31:0] home_speed_cmd, // homing speed command
	output logic [31:0] home_accel_cmd, // homing accel and decel
	output logic signed [31:0] zero_offset, // applied home offset
	output logic zero_load, // pulse: zero set at reference
	output logic block_hit // pushing against block
);
	logic torque_mode;
	logic homing_mode;
	logic halt;
	logic [15:0] lim_a;
	logic [15:0] lim_b;
	logic [15:0] lim_c;
	logic [15:0] lim;
	logic signed [17:0] lim_x;
	logic signed [17:0] tgt_x;
	logic signed [15:0] tgt_lim;
	logic signed [15:0] ramp_tgt;
	logic signed [17:0] set_sum;
	logic signed [17:0] err_x;
	logic [17:0] err_abs;
	logic [17:0] tgt_abs;
	logic in_win;
	logic torque_met;
	logic limit_exc;
	logic start_r;
	logic start_rise;
	logic homed_r;
	logic block_done;
	logic block_seen;
	logic [2:0] home_code;
	logic [15:0] status_nxt;
	dthm_home_t hstate_r;
	dthm_home_t hstate_nxt;

	assign torque_mode = (mode_sel == MODE_TORQUE);
	assign homing_mode = (mode_sel == MODE_HOMING);
	assign halt = ctrl_word[CW_HALT];

	// all quantities stay per-mille of rated; no rescaling anywhere
	always_comb begin
		lim_a = (max_current < max_torque) ? max_current : max_torque;
		lim_b = (motor_current_cap < lim_a) ? motor_current_cap : lim_a;
		lim_c = (overload_time == 16'h0000 && lim_b > RATED_PERMILLE) ?
			RATED_PERMILLE : lim_b;
		lim = (lim_c > TORQUE_CAP) ? TORQUE_CAP : lim_c;
	end

	assign lim_x = {2'b00, lim};
	assign tgt_x = 18'(target_torque);

	always_comb begin
		if (tgt_x > lim_x) begin
			tgt_lim = lim_x[15:0];
		end else if (tgt_x < -lim_x) begin
			tgt_lim = 16'(-lim_x);
		end else begin
			tgt_lim = target_torque;
		end
	end

	// halt or leaving the mode drives the ramp back down to zero torque
	assign ramp_tgt = (torque_mode && !halt) ? tgt_lim : 16'sh0000;

	dthm_ramp u_ramp (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.target(ramp_tgt),
		.slope(torque_slope),
		.demand(torque_demand)
	);

	assign set_sum = 18'(torque_demand) + 18'(torque_offset);

	// offset may push past the limit, so the sum is clamped again
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			torque_set <= TORQUE_RST;
		end else if (!torque_mode) begin
			torque_set <= TORQUE_RST;
		end else if (set_sum > lim_x) begin
			torque_set <= lim_x[15:0];
		end else if (set_sum < -lim_x) begin
			torque_set <= 16'(-lim_x);
		end else begin
			torque_set <= set_sum[15:0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			motor_hold <= 1'b1;
			speed_limit_en <= 1'b1;
			field_weak_en <= 1'b0;
		end else begin
			motor_hold <= halt;
			speed_limit_en <= !submode_sel;
			field_weak_en <= !submode_sel;
		end
	end

	assign err_x = 18'(torque_actual) - 18'(tgt_lim);
	assign err_abs = err_x[17] ? 18'(-err_x) : err_x;
	assign in_win = (err_abs <= {2'b00, torque_window});
	assign tgt_abs = tgt_x[17] ? 18'(-tgt_x) : tgt_x;
	assign limit_exc = (tgt_abs > {2'b00, max_torque});

	dthm_ms_timer #(
		.TICK_CYC(TICK_CYC)
	) u_win_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.enable(torque_mode && !halt && in_win),
		.limit_ms(torque_window_ms),
		.done(torque_met)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			start_r <= 1'b0;
		end else begin
			start_r <= ctrl_word[CW_HOME_START];
		end
	end

	assign start_rise = ctrl_word[CW_HOME_START] && !start_r;
	assign block_seen = (homing_method < 8'sh00) &&
		(motor_current > block_current);

	dthm_ms_timer #(
		.TICK_CYC(TICK_CYC)
	) u_block_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.enable(hstate_r == DTHM_H_BLOCK),
		.limit_ms(block_period_ms),
		.done(block_done)
	);

	always_comb begin
		hstate_nxt = hstate_r;
		case (hstate_r)
			DTHM_H_IDLE: begin
				if (homing_mode && start_rise) begin
					hstate_nxt = DTHM_H_RUN;
				end
			end
			DTHM_H_RUN: begin
				if (!homing_mode || !ctrl_word[CW_HOME_START]) begin
					hstate_nxt = DTHM_H_IDLE;
				end else if (home_fault) begin
					hstate_nxt = DTHM_H_FAIL;
				end else if (block_seen) begin
					hstate_nxt = DTHM_H_BLOCK;
				end else if (ref_found) begin
					hstate_nxt = DTHM_H_DONE;
				end
			end
			DTHM_H_BLOCK: begin
				if (!homing_mode || !ctrl_word[CW_HOME_START]) begin
					hstate_nxt = DTHM_H_IDLE;
				end else if (home_fault) begin
					hstate_nxt = DTHM_H_FAIL;
				end else if (block_done) begin
					hstate_nxt = DTHM_H_DONE;
				end
			end
			DTHM_H_DONE, DTHM_H_FAIL: begin
				if (!homing_mode || !ctrl_word[CW_HOME_START]) begin
					hstate_nxt = DTHM_H_IDLE;
				end
			end
			default: begin
				hstate_nxt = DTHM_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hstate_r <= DTHM_H_IDLE;
		end else begin
			hstate_r <= hstate_nxt;
		end
	end

	// an aborted run also leaves homed clear until a full completion
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			homed_r <= 1'b0;
		end else if (hstate_nxt == DTHM_H_DONE) begin
			homed_r <= 1'b1;
		end else if (hstate_nxt == DTHM_H_RUN || hstate_nxt == DTHM_H_FAIL) begin
			homed_r <= 1'b0;
		end
	end

	// method latched at start so a rewrite mid-run cannot change method_cmd; block_seen still uses the live homing_method
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			method_cmd <= 8'sh00;
		end else if (hstate_r == DTHM_H_IDLE && hstate_nxt == DTHM_H_RUN) begin
			method_cmd <= homing_method;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			home_speed_cmd <= WORD_RST;
			home_accel_cmd <= WORD_RST;
			homing_active <= 1'b0;
			block_hit <= 1'b0;
		end else begin
			homing_active <= (hstate_nxt == DTHM_H_RUN) ||
				(hstate_nxt == DTHM_H_BLOCK);
			block_hit <= (hstate_nxt == DTHM_H_BLOCK);
			if (hstate_nxt == DTHM_H_RUN) begin
				home_speed_cmd <= index_phase ? speed_index : speed_switch;
			end else if (hstate_nxt == DTHM_H_BLOCK) begin
				home_speed_cmd <= speed_switch;
			end else begin
				home_speed_cmd <= WORD_RST;
			end
			home_accel_cmd <= homing_accel;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			zero_offset <= WORD_RST;
			zero_load <= 1'b0;
		end else begin
			zero_load <= (hstate_nxt == DTHM_H_DONE) &&
				(hstate_r != DTHM_H_DONE);
			if (hstate_nxt == DTHM_H_DONE && hstate_r != DTHM_H_DONE) begin
				zero_offset <= home_offset;
			end
		end
	end

	always_comb begin
		case (hstate_r)
			DTHM_H_RUN, DTHM_H_BLOCK: home_code = HC_RUNNING;
			DTHM_H_DONE: home_code = HC_DONE;
			DTHM_H_FAIL: home_code = speed_zero ?
				HC_FAIL_STILL : HC_FAIL_MOVE;
			default: home_code = homed_r ? HC_HOMED : HC_IDLE;
		endcase
	end

	always_comb begin
		status_nxt = STATUS_RST;
		if (torque_mode) begin
			status_nxt[SW_TARGET] = halt ? speed_zero : torque_met;
			status_nxt[SW_LIMIT] = limit_exc;
		end else if (homing_mode) begin
			status_nxt[SW_ERROR] = home_code[2];
			status_nxt[SW_HOMED] = home_code[1];
			status_nxt[SW_TARGET] = home_code[0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_word <= STATUS_RST;
		end else begin
			status_word <= status_nxt;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_halt_decel: assert property (
		torque_mode && halt && torque_demand > 16'sh0000 |=>
		torque_demand <= $past(torque_demand))
		else $error("demand grew while halted");
	a_reach_window: assert property (
		torque_mode && !halt && !in_win |=> !status_word[SW_TARGET])
		else $error("target reached outside torque window");
	a_reach_halt: assert property (
		torque_mode && halt |=> status_word[SW_TARGET] == $past(speed_zero))
		else $error("halt target bit not standstill");
	a_limit_flag: assert property (
		torque_mode |=> status_word[SW_LIMIT] ==
		($past(tgt_abs) > {2'b00, $past(max_torque)}))
		else $error("limit bit wrong");
	a_set_clamp: assert property (
		torque_mode |=> 18'(torque_set) <= $past(lim_x) &&
		18'(torque_set) >= -$past(lim_x))
		else $error("torque set beyond limit");
	a_submode_sel: assert property (
		submode_sel |=> !speed_limit_en && !field_weak_en)
		else $error("pure torque still limited");
	a_home_abort: assert property (
		hstate_r == DTHM_H_RUN && !ctrl_word[CW_HOME_START] |=>
		hstate_r == DTHM_H_IDLE ##1 status_word[SW_TARGET])
		else $error("homing not aborted");
	a_homed_clear: assert property (
		homing_mode && hstate_r == DTHM_H_RUN |=> !status_word[SW_HOMED])
		else $error("homed bit set during run");
	a_fail_code: assert property (
		homing_mode && hstate_r == DTHM_H_FAIL |=> status_word[SW_ERROR] &&
		!status_word[SW_HOMED])
		else $error("fail code missing");
	a_block_detect: assert property (
		homing_mode && ctrl_word[CW_HOME_START] && !home_fault &&
		hstate_r == DTHM_H_RUN && block_seen |=> hstate_r == DTHM_H_BLOCK)
		else $error("block not detected");

	c_torque_met: cover property (torque_mode && !halt &&
		status_word[SW_TARGET]);
	c_halt_still: cover property (torque_mode && halt && status_word[SW_TARGET]);
	c_home_done: cover property (hstate_r == DTHM_H_DONE);
	c_block_done: cover property (hstate_r == DTHM_H_BLOCK ##1
		hstate_r == DTHM_H_DONE);
endmodule : dthm_drive_modes

// file: hdl/dthm_ms_timer.sv
// millisecond dwell timer: done once enable has held for limit ms
// assumes enable drops to restart; limit of zero is done at once
module dthm_ms_timer
	import dthm_pkg::*;
#(
	parameter int unsigned TICK_CYC = MS_CYCLES
) (
	input wire logic sys_clk, // control clock
	input wire logic reset_n, // async reset
	input wire logic enable, // condition holding
	input wire logic [15:0] limit_ms, // dwell in ms
	output logic done // dwell satisfied
);
	localparam int PW = $clog2(TICK_CYC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYC - 1);
	logic [PW-1:0] pre_r;
	logic [15:0] ms_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_r <= '0;
		end else if (!enable || pre_r == PRE_LAST) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// saturates so a long hold never wraps back to not-done
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ms_r <= '0;
		end else if (!enable) begin
			ms_r <= '0;
		end else if (pre_r == PRE_LAST && ms_r != 16'hffff) begin
			ms_r <= ms_r + 1'b1;
		end
	end

	assign done = enable && (ms_r >= limit_ms);
endmodule : dthm_ms_timer

// file: hdl/dthm_ramp.sv
// torque ramp: demand walks to target at no more than slope per second
// slope above the clock rate is limited to one step per cycle
module dthm_ramp
	import dthm_pkg::*;
(
	input wire logic sys_clk, // control clock
	input wire logic reset_n, // async reset
	input wire logic signed [15:0] target, // ramp target
	input wire logic [31:0] slope, // per-mille per second
	output logic signed [15:0] demand // ramp output
);
	localparam logic [32:0] HZ = 33'(CLK_HZ);
	logic [31:0] acc_r;
	logic [32:0] acc_sum;
	logic [32:0] acc_left;
	logic step;

	assign acc_sum = {1'b0, acc_r} + {1'b0, slope};
	assign step = (acc_sum >= HZ) && (demand != target);
	assign acc_left = acc_sum - HZ;

	// remainder kept so the long-run rate matches any slope up to the clock rate exactly
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_r <= WORD_RST;
		end else if (demand == target) begin
			acc_r <= WORD_RST;
		end else if (step) begin
			acc_r <= (acc_left < HZ) ? acc_left[31:0] : WORD_RST;
		end else begin
			acc_r <= acc_sum[31:0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			demand <= TORQUE_RST;
		end else if (step && demand < target) begin
			demand <= demand + 16'sh0001;
		end else if (step) begin
			demand <= demand - 16'sh0001;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_ramp_step_one: assert property (
		(demand - $past(demand) <= 1) && ($past(demand) - demand <= 1))
		else $error("ramp moved more than one step");
endmodule : dthm_ramp

// file: inc/dthm_pkg.sv
// constants shared by the torque and homing mode logic
// assumes one 20 MHz control clock and per-mille torque units throughout
package dthm_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned MS_UNIT = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_UNIT;
	localparam logic [7:0] MODE_TORQUE = 8'h04;
	localparam logic [7:0] MODE_HOMING = 8'h06;
	localparam int CW_HOME_START = 4;
	localparam int CW_HALT = 8;
	localparam int SW_TARGET = 10;
	localparam int SW_LIMIT = 11;
	localparam int SW_HOMED = 12;
	localparam int SW_ERROR = 13;
	localparam logic [15:0] RATED_PERMILLE = 16'h03e8;
	localparam logic [15:0] TORQUE_CAP = 16'h7fff;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] TORQUE_RST = 16'h0000;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [2:0] HC_RUNNING = 3'h0;
	localparam logic [2:0] HC_IDLE = 3'h1;
	localparam logic [2:0] HC_HOMED = 3'h2;
	localparam logic [2:0] HC_DONE = 3'h3;
	localparam logic [2:0] HC_FAIL_MOVE = 3'h4;
	localparam logic [2:0] HC_FAIL_STILL = 3'h5;
	typedef enum logic [2:0] {
		DTHM_H_IDLE,
		DTHM_H_RUN,
		DTHM_H_BLOCK,
		DTHM_H_DONE,
		DTHM_H_FAIL
	} dthm_home_t;
endpackage : dthm_pkg

// file: verification/dthm_drive_modes_bench.sv
// self-checking bench for torque and homing mode control
// assumes a 1 ms tick of 20 cycles; master model sets mode and control
module dthm_drive_modes_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dthm_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic want_home = 1'b0, want_torque = 1'b1, halt_req = 1'b1;
	logic start_req = 1'b0, submode_sel = 1'b0, speed_zero = 1'b0;
	logic index_phase = 1'b0, ref_found = 1'b0, home_fault = 1'b0;
	logic signed [15:0] target_torque = 16'h0384, torque_offset = 16'h0000;
	logic signed [15:0] torque_actual = 16'h0000;
	logic [15:0] max_torque = 16'h012c, max_current = 16'h03e8;
	logic [15:0] motor_current_cap = 16'h07d0, overload_time = 16'h0000;
	logic [15:0] torque_window = 16'h0005, torque_window_ms = 16'h0001;
	logic [15:0] motor_current = 16'h0000, block_current = 16'h0100;
	logic [15:0] block_period_ms = 16'h0002;
	logic [31:0] torque_slope = 32'h0131_2d00, speed_switch = 32'h0000_0064;
	logic [31:0] speed_index = 32'h0000_000a, homing_accel = 32'h0000_0200;
	logic signed [31:0] home_offset = 32'h0000_1234;
	logic signed [7:0] homing_method = 8'h11;
	logic [7:0] mode_sel;
	logic [15:0] ctrl_word, status_word;
	logic signed [15:0] torque_demand, torque_set;
	logic motor_hold, speed_limit_en, field_weak_en, homing_active;
	logic zero_load, block_hit;
	logic signed [7:0] method_cmd;
	logic [31:0] home_speed_cmd, home_accel_cmd;
	logic signed [31:0] zero_offset;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	integer seed = 32'he7ab;
	logic signed [15:0] prev;

	dthm_master_model master (.want_home(want_home), .want_torque(want_torque),
		.halt_req(halt_req), .start_req(start_req), .mode_sel(mode_sel),
		.ctrl_word(ctrl_word), .travel_block());
	dthm_drive_modes #(.TICK_CYC(20)) dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .mode_sel(mode_sel), .ctrl_word(ctrl_word),
		.submode_sel(submode_sel), .target_torque(target_torque),
		.max_torque(max_torque), .max_current(max_current),
		.motor_current_cap(motor_current_cap), .overload_time(overload_time),
		.torque_slope(torque_slope), .torque_offset(torque_offset),
		.torque_window(torque_window), .torque_window_ms(torque_window_ms),
		.torque_actual(torque_actual), .speed_zero(speed_zero),
		.motor_current(motor_current), .home_offset(home_offset),
		.homing_method(homing_method), .speed_switch(speed_switch),
		.speed_index(speed_index), .homing_accel(homing_accel),
		.block_current(block_current), .block_period_ms(block_period_ms),
		.index_phase(index_phase), .ref_found(ref_found),
		.home_fault(home_fault), .status_word(status_word),
		.torque_demand(torque_demand), .torque_set(torque_set),
		.motor_hold(motor_hold), .speed_limit_en(speed_limit_en),
		.field_weak_en(field_weak_en), .homing_active(homing_active),
		.method_cmd(method_cmd), .home_speed_cmd(home_speed_cmd),
		.home_accel_cmd(home_accel_cmd), .zero_offset(zero_offset),
		.zero_load(zero_load), .block_hit(block_hit));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// longest path is five random ramps of up to 5000 steps each
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 50000) begin
			failures++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : check

	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	function automatic logic [2:0] code();
		return {status_word[SW_ERROR], status_word[SW_HOMED],
			status_word[SW_TARGET]};
	endfunction : code

	task wait_code(input logic [2:0] c, input int lim);
		for (int i = 0; i < lim && code() !== c; i++)
			@(negedge sys_clk);
		check(code(), c);
	endtask : wait_code

	task wait_demand(input int v, input int lim);
		for (int i = 0; i < lim && torque_demand !== v; i++)
			@(negedge sys_clk);
		check(torque_demand, v);
	endtask : wait_demand

	// per-mille limit chain, then clamp of the commanded torque
	function automatic int exp_lim();
		int lim;
		lim = max_current;
		if (max_torque < lim) lim = max_torque;
		if (motor_current_cap < lim) lim = motor_current_cap;
		if (overload_time == 16'h0000 && lim > 1000) lim = 1000;
		return lim;
	endfunction : exp_lim

	function automatic int exp_clamp(input int v);
		if (v > exp_lim()) return exp_lim();
		if (v < -exp_lim()) return -exp_lim();
		return v;
	endfunction : exp_clamp

	function automatic int exp_demand();
		return exp_clamp(target_torque);
	endfunction : exp_demand

	// offset can push past the limit, so the set value is capped again
	function automatic int exp_set();
		return exp_clamp(exp_demand() + torque_offset);
	endfunction : exp_set

	function automatic logic over_max();
		int t;
		t = target_torque;
		return (t < 0 ? -t : t) > max_torque;
	endfunction : over_max

	initial begin
		cyc(20);
		check(motor_hold, 1'b1);
		check(speed_limit_en, 1'b1);
		reset_n = 1'b1;
		cyc(2);
		check(motor_hold, 1'b1);
		check(torque_demand, 0);
		check(status_word[SW_LIMIT], 1'b1);
		cyc(2);
		check(status_word[SW_TARGET], 1'b0);
		speed_zero = 1'b1;
		cyc(2);
		check(status_word[SW_TARGET], 1'b1);
		halt_req = 1'b0;
		cyc(2);
		check(motor_hold, 1'b0);
		repeat (10) begin
			prev = torque_demand;
			cyc(1);
			check(torque_demand - prev <= 1, 1'b1);
		end
		check(torque_demand < 300, 1'b1);
		wait_demand(300, 400);
		torque_offset = -16'sd7;
		cyc(2);
		check(torque_set, 293);
		torque_actual = 16'h012c;
		cyc(3);
		check(status_word[SW_TARGET], 1'b0);
		cyc(45);
		check(status_word[SW_TARGET], 1'b1);
		for (int s = 1; s >= 0; s--) begin
			submode_sel = s[0];
			cyc(2);
			check(speed_limit_en, !s[0]);
			check(field_weak_en, !s[0]);
		end
		repeat (5) begin
			target_torque = 16'($random(seed) % 2500);
			max_torque = 16'($unsigned($random(seed)) % 1900);
			max_current = 16'(200 + $unsigned($random(seed)) % 1800);
			motor_current_cap = 16'(200 + $unsigned($random(seed)) % 1800);
			overload_time = $random(seed) & 1 ? 16'h0010 : 16'h0000;
			torque_offset = 16'($random(seed) % 50);
			cyc(1);
			wait_demand(exp_demand(), 6000);
			// set value is registered one cycle behind the demand
			cyc(1);
			check(torque_set, exp_set());
			check(status_word[SW_LIMIT], over_max());
		end
		// halt from a running torque must ramp the demand down
		target_torque = 16'sd200;
		max_torque = 16'h012c;
		wait_demand(200, 6000);
		halt_req = 1'b1;
		speed_zero = 1'b0;
		cyc(2);
		check(motor_hold, 1'b1);
		check(status_word[SW_TARGET], 1'b0);
		check(torque_demand < 200, 1'b1);
		wait_demand(0, 6000);
		halt_req = 1'b0;
		want_torque = 1'b0;
		want_home = 1'b1;
		speed_zero = 1'b0;
		cyc(2);
		check(code(), HC_IDLE);
		check(torque_set, 0);
		check(status_word[SW_LIMIT], 1'b0);
		start_req = 1'b1;
		wait_code(HC_RUNNING, 5);
		check(homing_active, 1'b1);
		check(method_cmd, homing_method);
		check(home_accel_cmd, homing_accel);
		check(home_speed_cmd, speed_switch);
		index_phase = 1'b1;
		cyc(2);
		check(home_speed_cmd, speed_index);
		ref_found = 1'b1;
		cyc(1);
		check(zero_load, 1'b1);
		ref_found = 1'b0;
		wait_code(HC_DONE, 5);
		check(zero_load, 1'b0);
		check(zero_offset, home_offset);
		start_req = 1'b0;
		wait_code(HC_HOMED, 5);
		start_req = 1'b1;
		wait_code(HC_RUNNING, 5);
		home_fault = 1'b1;
		cyc(1);
		home_fault = 1'b0;
		wait_code(HC_FAIL_MOVE, 5);
		speed_zero = 1'b1;
		wait_code(HC_FAIL_STILL, 5);
		start_req = 1'b0;
		speed_zero = 1'b0;
		wait_code(HC_IDLE, 5);
		start_req = 1'b1;
		wait_code(HC_RUNNING, 5);
		start_req = 1'b0;
		wait_code(HC_IDLE, 5);
		// negative method number selects homing on a mechanical block
		homing_method = 8'hef;
		index_phase = 1'b0;
		start_req = 1'b1;
		wait_code(HC_RUNNING, 5);
		motor_current = 16'h0200;
		cyc(3);
		check(block_hit, 1'b1);
		cyc(30);
		check(code(), HC_RUNNING);
		wait_code(HC_DONE, 60);
		final_report();
	end
endmodule : dthm_drive_modes_bench

// file: verification/dthm_master_model.sv
// fieldbus master stand-in owning mode select and control word
// assumes bench commands change at the falling edge; outputs follow at once
module dthm_master_model
	import dthm_pkg::*;
(
	input wire logic want_home, // request homing mode
	input wire logic want_torque, // request profile torque mode
	input wire logic halt_req, // hold the motor
	input wire logic start_req, // homing start level
	output logic [7:0] mode_sel, // modes of operation
	output logic [15:0] ctrl_word, // control word
	output logic [15:0] travel_block // limit switch travel block
);
	// factory value kept so limit switches never block travel
	assign travel_block = 16'hffff;
	assign mode_sel = want_home ? MODE_HOMING :
		(want_torque ? MODE_TORQUE : 8'h00);
	always_comb begin
		ctrl_word = 16'h0000;
		ctrl_word[CW_HALT] = halt_req;
		ctrl_word[CW_HOME_START] = start_req;
	end
endmodule : dthm_master_model
